//--- logic/afe_i2c_params.svh
// Behaviour
// - scl held low past the timeout limit returns the serial interface to idle
// - sda held low by us past the timeout limit resets interface, releasing sda
// - standard mode only, bus clock up to 100 kHz
// - drive sda low for zero, release it for one, never drive high
// - answer only the fixed 7-bit target address 1001000
// - start is sda falling while scl high, and begins a frame
// - address of seven bits plus direction bit, then acknowledge slot
// - acknowledge a matching address, not a mismatching one
// - in a write, the pointer byte follows and is acknowledged
// - data bytes follow the pointer, each acknowledged and stored at the pointer except into status, or into gain or reference while locked
// - after read address acknowledge, shift out the pointed register byte
// - with bus_select_n high ignore all traffic and never acknowledge
// - gain field picks one of seven internal resistors or external option
// - divider field picks internal zero of 67, 50 or 20 percent
// - power saving turns off the current stage and switches in a load
`ifndef AFE_I2C_PARAMS_SVH
`define AFE_I2C_PARAMS_SVH

`define TARGET_ADDR        7'h48
`define SYS_CLK_HZ         100000000
`define TIMEOUT_MS         25
`define TIMEOUT_CYCLES     ((`SYS_CLK_HZ / 1000) * `TIMEOUT_MS)
`define BUS_MAX_KHZ        100

`define OFS_STATUS         8'h00
`define OFS_LOCK           8'h01
`define OFS_GAIN           8'h10
`define OFS_REF            8'h11
`define OFS_MODE           8'h12

`define RST_LOCK           8'h01
`define RST_GAIN           8'h03
`define RST_REF            8'h20
`define RST_MODE           8'h00
`define STATUS_READY       8'h01

`define GAIN_LSB           2
`define GAIN_MSB           4
`define INTZ_LSB           5
`define INTZ_MSB           6
`define REFSRC_BIT         7
`define MODE_LSB           0
`define MODE_MSB           2
`define SHORT_BIT          7
`define LOCK_BIT           0
`define MODE_DEEP_SLEEP    3'h0
`define MODE_STANDBY       3'h2
`define MODE_AMPERO        3'h3
`define GAIN_EXTERNAL      3'h0

`endif

//--- logic/afe_i2c_pkg.sv
package afe_i2c_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } bus_state_t;

    // analog configuration outputs gathered in one carrier
    typedef struct packed {
        logic [2:0] gain_sel;
        logic [1:0] zero_sel;
        logic       ref_external;
        logic       stage_on;
        logic       load_switch;
        logic       counter_amp_on;
        logic       short_fet;
    } afe_config_t;

    // line sample history
    typedef struct packed {
        logic scl;
        logic sda;
    } line_pair_t;

endpackage : afe_i2c_pkg

//--- logic/afe_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_i2c_params.svh"

// small register bank with registered read data
module afe_reg_bank (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    output logic      [7:0] rd_data_out,
    output logic      [7:0] lock_reg_out,
    output logic      [7:0] gain_reg_out,
    output logic      [7:0] ref_reg_out,
    output logic      [7:0] mode_reg_out
);

    logic [7:0] next_lock;
    logic [7:0] next_gain;
    logic [7:0] next_ref;
    logic [7:0] next_mode;
    logic [7:0] next_rd;
    logic       unlocked;

    // writes; gain and reference refuse writes while locked
    always_comb begin
        unlocked  = ~lock_reg_out[`LOCK_BIT];
        next_lock = lock_reg_out;
        next_gain = gain_reg_out;
        next_ref  = ref_reg_out;
        next_mode = mode_reg_out;
        if (wr_en_in) begin
            unique case (addr_in)
                `OFS_LOCK: next_lock = {7'h00, wr_data_in[`LOCK_BIT]};
                `OFS_GAIN: if (unlocked) next_gain = wr_data_in;
                `OFS_REF:  if (unlocked) next_ref = wr_data_in;
                `OFS_MODE: next_mode = wr_data_in;
                default:   ;
            endcase
        end
        unique case (addr_in)
            `OFS_STATUS: next_rd = `STATUS_READY;
            `OFS_LOCK:   next_rd = lock_reg_out;
            `OFS_GAIN:   next_rd = gain_reg_out;
            `OFS_REF:    next_rd = ref_reg_out;
            `OFS_MODE:   next_rd = mode_reg_out;
            default:     next_rd = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lock_reg_out <= `RST_LOCK;
            gain_reg_out <= `RST_GAIN;
            ref_reg_out  <= `RST_REF;
            mode_reg_out <= `RST_MODE;
            rd_data_out  <= 8'h00;
        end else begin
            lock_reg_out <= next_lock;
            gain_reg_out <= next_gain;
            ref_reg_out  <= next_ref;
            mode_reg_out <= next_mode;
            rd_data_out  <= next_rd;
        end
    end

endmodule : afe_reg_bank
`default_nettype wire

//--- logic/sensor_afe_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_i2c_params.svh"

module sensor_afe_i2c_target
    import afe_i2c_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input  wire logic  sys_clk_in,
    input  wire logic  rst_b_in,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    input  wire logic  bus_select_n_in,
    output logic       sda_out,
    output logic       sda_oe_out,
    output afe_config_t config_out,
    output logic       timeout_out
);

    // ------------------------------------------------------------
    // line sampling and condition detect
    // ------------------------------------------------------------
    line_pair_t line;
    line_pair_t line_d;
    line_pair_t next_line;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;

    // inputs are synchronous already; two stages give edge history
    always_comb begin
        next_line.scl = scl_in;
        next_line.sda = sda_in;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line   <= '{scl: 1'b1, sda: 1'b1};
            line_d <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            line   <= next_line;
            line_d <= line;
        end
    end

    // both conditions need scl high in two samples, so an sda move right at an scl edge is not taken
    assign start_det = line_d.scl & line.scl & line_d.sda & ~line.sda;
    assign stop_det  = line_d.scl & line.scl & ~line_d.sda & line.sda;
    assign scl_rise  = ~line_d.scl & line.scl;
    assign scl_fall  = line_d.scl & ~line.scl;

    // ------------------------------------------------------------
    // stuck-line timeout
    // ------------------------------------------------------------
    localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
    logic [TW-1:0] stuck_cnt;
    logic [TW-1:0] next_stuck_cnt;
    logic          stuck_hit;
    logic          next_timeout;

    // counts only while scl or our own sda is low; bus at rest never trips
    // one counter serves both stuck cases; a hit drops our sda drive and the frame
    // limitation: the limit is in system clocks, so it scales with the clock rate
    always_comb begin
        stuck_hit      = 1'b0;
        next_stuck_cnt = stuck_cnt;
        if ((line.scl != line_d.scl) || (line.sda != line_d.sda)) begin
            next_stuck_cnt = '0;
        end else if (~line.scl || sda_oe_out) begin
            if (stuck_cnt >= TW'(TIMEOUT_CYCLES - 1)) begin
                stuck_hit      = 1'b1;
                next_stuck_cnt = '0;
            end else begin
                next_stuck_cnt = stuck_cnt + 1'b1;
            end
        end else begin
            next_stuck_cnt = '0;
        end
        next_timeout = stuck_hit;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stuck_cnt   <= '0;
            timeout_out <= 1'b0;
        end else begin
            stuck_cnt   <= next_stuck_cnt;
            timeout_out <= next_timeout;
        end
    end

    // ------------------------------------------------------------
    // protocol state machine
    // ------------------------------------------------------------
    bus_state_t state;
    bus_state_t next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    logic [1:0] byte_idx;
    logic [1:0] next_byte_idx;
    logic       is_read;
    logic       next_is_read;
    logic       ack_hold;
    logic       next_ack_hold;
    logic       next_sda_oe;
    logic       wr_en;
    logic [7:0] rd_data;
    logic [7:0] lock_reg;
    logic [7:0] gain_reg;
    logic [7:0] ref_reg;
    logic [7:0] mode_reg;
    logic [7:0] rx_byte;

    assign rx_byte = {shift[6:0], line.sda};

    // frame flow: address byte, ack slot, then pointer byte and data bytes
    // a read address hands out the register at the pointer after its ack slot
    // the ack is held through one full scl high phase and dropped at the next fall
    // limitation: no clock stretching, the register data must be ready in time
    // trade-off: read data come from a flop, fed by a pointer set a byte earlier
    always_comb begin
        next_state    = state;
        next_shift    = shift;
        next_bit_cnt  = bit_cnt;
        next_pointer  = pointer;
        next_byte_idx = byte_idx;
        next_is_read  = is_read;
        next_ack_hold = ack_hold;
        next_sda_oe   = sda_oe_out;
        wr_en         = 1'b0;
        if (bus_select_n_in || stuck_hit) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (stop_det) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_det) begin
            next_state    = ST_ADDR;
            next_bit_cnt  = 4'h0;
            next_byte_idx = 2'h0;
            next_sda_oe   = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_IGNORE: ;
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_shift   = rx_byte;
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        if (shift[7:1] == `TARGET_ADDR) begin
                            next_sda_oe   = 1'b1;
                            next_is_read  = shift[0];
                            next_state    = ST_ACK;
                            next_ack_hold = 1'b0;
                        end else begin
                            next_state = ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_rise) next_ack_hold = 1'b1;
                    if (scl_fall && ack_hold) begin
                        next_sda_oe  = 1'b0;
                        next_bit_cnt = 4'h0;
                        if (is_read && byte_idx == 2'h0) begin
                            next_state  = ST_TX;
                            next_shift  = rd_data;
                            next_sda_oe = ~rd_data[7];
                        end else begin
                            next_state = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_shift   = rx_byte;
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        if (byte_idx == 2'h0) begin
                            next_pointer = shift;
                        end else begin
                            wr_en = 1'b1;
                        end
                        next_byte_idx = 2'h1;
                        next_sda_oe   = 1'b1;
                        next_state    = ST_ACK;
                        next_ack_hold = 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_rise) next_bit_cnt = bit_cnt + 4'h1;
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_sda_oe = 1'b0;
                            next_state  = ST_TX_ACK;
                        end else begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    // controller nack ends the read; ack sends the same register again
                    if (scl_rise) begin
                        next_state   = line.sda ? ST_IGNORE : ST_ACK;
                        next_ack_hold = 1'b1;
                    end
                end
                default: begin
                    next_state  = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // register the whole interface state
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state      <= ST_IDLE;
            shift      <= 8'h00;
            bit_cnt    <= 4'h0;
            pointer    <= 8'h00;
            byte_idx   <= 2'h0;
            is_read    <= 1'b0;
            ack_hold   <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            state      <= next_state;
            shift      <= next_shift;
            bit_cnt    <= next_bit_cnt;
            pointer    <= next_pointer;
            byte_idx   <= next_byte_idx;
            is_read    <= next_is_read;
            ack_hold   <= next_ack_hold;
            sda_oe_out <= next_sda_oe;
        end
    end

    // ------------------------------------------------------------
    // sda drive
    // ------------------------------------------------------------

    // open drain: the output value is always low, only the enable moves
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) sda_out <= 1'b0;
        else           sda_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // the bank only sees the pointer and the finished byte, never a partial one
    afe_reg_bank u_regs (
        .sys_clk_in   (sys_clk_in),
        .rst_b_in     (rst_b_in),
        .wr_en_in     (wr_en),
        .addr_in      (pointer),
        .wr_data_in   (shift),
        .rd_data_out  (rd_data),
        .lock_reg_out (lock_reg),
        .gain_reg_out (gain_reg),
        .ref_reg_out  (ref_reg),
        .mode_reg_out (mode_reg)
    );

    // ------------------------------------------------------------
    // analog control decode
    // ------------------------------------------------------------
    afe_config_t next_config;
    logic [2:0]  op_mode;

    // decode register fields into analog controls
    always_comb begin
        op_mode                    = mode_reg[`MODE_MSB:`MODE_LSB];
        next_config.gain_sel       = gain_reg[`GAIN_MSB:`GAIN_LSB];
        next_config.zero_sel       = ref_reg[`INTZ_MSB:`INTZ_LSB];
        next_config.ref_external   = ref_reg[`REFSRC_BIT];
        next_config.stage_on       = (op_mode == `MODE_AMPERO);
        next_config.load_switch    = (op_mode != `MODE_AMPERO);
        next_config.counter_amp_on = (op_mode == `MODE_AMPERO) || (op_mode == `MODE_STANDBY);
        next_config.short_fet      = mode_reg[`SHORT_BIT];
    end

    // registered so every analog control comes straight from a flop, glitch free
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) config_out <= '0;
        else           config_out <= next_config;
    end

endmodule : sensor_afe_i2c_target
`default_nettype wire

//--- tb/afe_i2c_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module afe_i2c_chk
    import afe_i2c_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        bus_select_n_in,
    input  wire logic        sda_out,
    input  wire logic        sda_oe_out,
    input  wire afe_config_t config_out,
    input  wire logic        timeout_out
);
    int unsigned stuck_cnt, next_stuck_cnt;
    logic        fired, next_fired, scl_q, sda_q;
    // own stuck-line count; restarts on raw edges, so it runs ahead of the synced one
    always_comb begin
        next_stuck_cnt = stuck_cnt;
        next_fired = fired | timeout_out;
        if (scl_in != scl_q || sda_in != sda_q || (scl_in && !sda_oe_out)) begin
            next_stuck_cnt = 0;
            next_fired = 1'b0;
        end else if (stuck_cnt < TIMEOUT_CYCLES + 16) begin
            next_stuck_cnt = stuck_cnt + 1; // saturates, no wrap
        end
    end
    // register helper state
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stuck_cnt <= 0;
            fired <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            stuck_cnt <= next_stuck_cnt;
            fired <= next_fired;
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_sda_never_high: assert property (!sda_out)
        else $error("sda driven high");
    a_deselect_quiet: assert property (bus_select_n_in [*8] |-> !sda_oe_out)
        else $error("ack while deselected");
    a_oe_moves_low: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("sda moved with scl high");
    a_pulse_once: assert property (timeout_out |=> !timeout_out)
        else $error("timeout pulse too long");
    a_timeout_late: assert property (timeout_out |-> stuck_cnt >= TIMEOUT_CYCLES - 8)
        else $error("timeout too early");
    a_timeout_due: assert property (stuck_cnt == TIMEOUT_CYCLES + 8 |-> fired)
        else $error("timeout missing");
    a_release_to: assert property (timeout_out |-> ##[1:4] !sda_oe_out)
        else $error("sda kept after timeout");
    a_stage_load: assert property ($past(rst_b_in) |-> config_out.stage_on != config_out.load_switch)
        else $error("stage and load both on or off");
    a_cfg_needs_sel: assert property ($past(rst_b_in, 2) && $changed(config_out) |-> !bus_select_n_in)
        else $error("config moved while deselected");
    a_reset_cfg: assert property ($rose(rst_b_in) |-> ##[0:2] config_out.load_switch
                                  && config_out.zero_sel == 2'h1)
        else $error("bad config after reset");
    c_timeout: cover property (timeout_out);
    c_ack: cover property ($rose(sda_oe_out));
    c_cfg: cover property ($past(rst_b_in, 2) && $changed(config_out));
endmodule : afe_i2c_chk

bind sensor_afe_i2c_target afe_i2c_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_afe_i2c_chk (
    .sys_clk_in, .rst_b_in, .scl_in, .sda_in, .bus_select_n_in,
    .sda_out, .sda_oe_out, .config_out, .timeout_out
);
`default_nettype wire

//--- tb/afe_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bus controller model, open drain, scl idles high
// ----
module afe_ctl_model #(
    parameter int HALF = 250 // four halves a bit: 100 kHz at 100 MHz
) (
    input  wire logic sys_clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out,
    output logic      sel_n_out
);
    // released lines at time zero
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        sel_n_out = 1'b1;
    end
    task automatic hw();
        repeat (HALF) @(negedge sys_clk_in);
    endtask : hw
    // one select at a time, held through the whole transfer
    task automatic select(input logic v);
        sel_n_out = v;
    endtask : select
    // data moves mid low phase, sampled at end of high phase
    task automatic bit_io(input logic b, output logic s);
        hw();
        sda_low_out = ~b;
        hw();
        scl_out = 1'b1;
        hw();
        hw();
        s = sda_in;
        scl_out = 1'b0;
    endtask : bit_io
    // also serves as repeated start from scl low
    task automatic start();
        hw();
        sda_low_out = 1'b0;
        hw();
        scl_out = 1'b1;
        hw();
        sda_low_out = 1'b1;
        hw();
        scl_out = 1'b0;
    endtask : start
    task automatic stop();
        hw();
        sda_low_out = 1'b1;
        hw();
        scl_out = 1'b1;
        hw();
        sda_low_out = 1'b0;
        hw();
    endtask : stop
    task automatic bits8(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    endtask : bits8
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        bits8(d);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    task automatic rd_byte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask : rd_byte
endmodule : afe_ctl_model
`default_nettype wire

//--- tb/sensor_afe_i2c_target_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_afe_i2c_target_tb;
    import afe_i2c_pkg::*;
    localparam int TO = 200; // short stuck limit keeps the run brief
    logic        sys_clk_in, rst_b_in, scl, sda_low, sel_n, sda_out, sda_oe_out, timeout_out;
    afe_config_t cfg;
    int          bad_count, n_compared;
    // pull-up wins unless someone pulls low
    wire logic   sda = ~(sda_low | (sda_oe_out & ~sda_out));
    sensor_afe_i2c_target #(.TIMEOUT_CYCLES(TO)) i_sensor_afe_i2c_target (
        .sys_clk_in, .rst_b_in, .scl_in(scl), .sda_in(sda), .bus_select_n_in(sel_n),
        .sda_out, .sda_oe_out, .config_out(cfg), .timeout_out);
    afe_ctl_model #(.HALF(6)) i_afe_ctl_model (
        .sys_clk_in, .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low), .sel_n_out(sel_n));
    // ----
    // clock and helpers
    // ----
    initial sys_clk_in = 1'b0;
    always #5 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic [2:0] ak,
                      input logic [6:0] a = 7'h48);
        i_afe_ctl_model.start();
        i_afe_ctl_model.wr_byte({a, 1'b0}, ak[2]);
        i_afe_ctl_model.wr_byte(p, ak[1]);
        i_afe_ctl_model.wr_byte(d, ak[0]);
        i_afe_ctl_model.stop();
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic [2:0] ak;
        logic [7:0] d;
        i_afe_ctl_model.start();
        i_afe_ctl_model.wr_byte({7'h48, 1'b0}, ak[2]);
        i_afe_ctl_model.wr_byte(p, ak[1]);
        i_afe_ctl_model.start();
        i_afe_ctl_model.wr_byte({7'h48, 1'b1}, ak[0]);
        i_afe_ctl_model.rd_byte(d, 1'b1);
        i_afe_ctl_model.stop();
        chk(ak, 3'h7);
        chk(d, exp);
    endtask : rd
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        chk(cfg, {3'h0, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
        chk(sda_oe_out, 1'b0);
    endtask : t_reset
    task automatic t_modes();
        logic [7:0] mv [3] = '{8'h03, 8'h02, 8'h80};
        logic [3:0] ev [3] = '{4'b1010, 4'b0110, 4'b0101};
        logic [2:0] ak;
        for (int i = 0; i < 3; i++) begin
            wr(8'h12, mv[i], ak);
            chk(ak, 3'h7);
            chk({cfg.stage_on, cfg.load_switch, cfg.counter_amp_on, cfg.short_fet}, ev[i]);
        end
    endtask : t_modes
    // locked gain write is dropped, then every gain code incl. external
    task automatic t_gain();
        logic [2:0] ak;
        wr(8'h10, 8'h1c, ak);
        chk(cfg.gain_sel, 3'h0);
        wr(8'h01, 8'h00, ak);
        for (int g = 0; g < 8; g++) begin
            wr(8'h10, {3'h0, g[2:0], 2'h0}, ak);
            chk(cfg.gain_sel, g[2:0]);
        end
    endtask : t_gain
    task automatic t_ref();
        logic [2:0] ak;
        for (int z = 0; z < 3; z++) begin
            wr(8'h11, {z[0], z[1:0], 5'h0}, ak);
            chk({cfg.ref_external, cfg.zero_sel}, {z[0], z[1:0]});
        end
    endtask : t_ref
    task automatic t_read();
        rd(8'h10, 8'h1c);
        rd(8'h00, 8'h01);
        rd(8'h11, 8'h40);
    endtask : t_read
    // foreign addresses, then our address while deselected
    task automatic t_refuse();
        logic [6:0] av [3] = '{7'h49, 7'h08, 7'h68};
        logic [2:0] ak;
        for (int i = 0; i < 3; i++) begin
            wr(8'h12, 8'h03, ak, av[i]);
            chk(ak, 3'h0);
        end
        i_afe_ctl_model.select(1'b1);
        wr(8'h12, 8'h03, ak);
        chk(ak, 3'h0);
        i_afe_ctl_model.select(1'b0);
        chk(cfg.stage_on, 1'b0);
    endtask : t_refuse
    // stop in mid data byte must not leave a half byte behind
    task automatic t_abort();
        logic [2:0] ak;
        logic       s;
        i_afe_ctl_model.start();
        i_afe_ctl_model.wr_byte(8'h90, ak[2]);
        i_afe_ctl_model.wr_byte(8'h12, ak[1]);
        for (int i = 0; i < 4; i++) i_afe_ctl_model.bit_io(1'b1, s);
        i_afe_ctl_model.stop();
        chk(cfg.stage_on, 1'b0);
        wr(8'h12, 8'h03, ak);
        chk(ak, 3'h7);
        chk(cfg.stage_on, 1'b1);
    endtask : t_abort
    // scl parked low while we hold the address ack
    task automatic t_timeout();
        logic [2:0] ak;
        int         k;
        i_afe_ctl_model.start();
        i_afe_ctl_model.bits8(8'h90);
        repeat (4) @(negedge sys_clk_in);
        chk(sda_oe_out, 1'b1);
        for (k = 0; k < 300 && timeout_out !== 1'b1; k++) @(negedge sys_clk_in);
        if (k == 300) begin
            bad_count++;
            tally_and_finish();
        end
        chk(k > TO - 20 && k < TO + 20, 1'b1);
        repeat (4) @(negedge sys_clk_in);
        chk(sda_oe_out, 1'b0);
        i_afe_ctl_model.stop();
        wr(8'h12, 8'h02, ak);
        chk(ak, 3'h7);
    endtask : t_timeout
    // ----
    // main sequence
    // ----
    initial begin
        rst_b_in = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (10) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        i_afe_ctl_model.select(1'b0);
        t_reset();
        t_modes();
        t_gain();
        t_ref();
        t_read();
        t_refuse();
        t_abort();
        t_timeout();
        tally_and_finish();
    end
endmodule : sensor_afe_i2c_target_tb
`default_nettype wire
